/* File: hw/tbs_defines.svh */
`ifndef TBS_DEFINES_SVH
`define TBS_DEFINES_SVH

// Register offsets on the plain register port.
`define TBS_OFF_FINGER 4'h0
`define TBS_OFF_HYST 4'h1
`define TBS_OFF_NOISE 4'h2
`define TBS_OFF_NEG_NOISE 4'h3
`define TBS_OFF_LOW_RESET 4'h4
`define TBS_OFF_DEBOUNCE 4'h5
`define TBS_OFF_CTRL 4'h6
`define TBS_OFF_STATUS 4'h7
`define TBS_OFF_BASELINE 4'h8
`define TBS_OFF_SIGNAL 4'h9
`define TBS_OFF_CENTROID 4'hA

// Control register field positions.
`define TBS_CTRL_AUTO_RESET 0
`define TBS_CTRL_MULTI_FREQ 1
`define TBS_CTRL_NOTOUCH_ONES 2
`define TBS_CTRL_SHIFT_LO 4
`define TBS_CTRL_SHIFT_HI 7

// Reset values of the configuration registers.
`define TBS_RST_FINGER 16'h0050
`define TBS_RST_HYST 16'h000A
`define TBS_RST_NOISE 16'h0028
`define TBS_RST_NEG_NOISE 16'h0028
`define TBS_RST_LOW_RESET 16'h001E
`define TBS_RST_DEBOUNCE 16'h0003
`define TBS_RST_CTRL 16'h0020

// Fixed no-touch centroid codes.
`define TBS_CENTROID_ONES 16'hFFFF
`define TBS_CENTROID_ZEROS 16'h0000

`endif

/* File: hw/tbs_pkg.sv */
package tbs_pkg;

    // One register access from the plain register port.
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tbs_bus_type;

    // Settings that steer the baseline and state logic.
    typedef struct packed {
        logic [15:0] finger;
        logic [15:0] hyst;
        logic [15:0] noise;
        logic [15:0] neg_noise;
        logic [15:0] low_reset;
        logic [15:0] debounce;
        logic auto_reset;
        logic multi_freq;
        logic notouch_ones;
        logic [3:0] shift;
    } tbs_cfg_type;

    // Baseline tracker phases.
    typedef enum logic [1:0] {
        TBS_FIRST,
        TBS_TRACK
    } tbs_phase_type;

endpackage : tbs_pkg

/* File: hw/tbs_median3.sv */
`timescale 1ns/1ps
`default_nettype none

// Collects three difference counts and emits their median.
module tbs_median3 #(
    parameter int WIDTH = 17
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic signed [WIDTH-1:0] in_diff,
    output logic out_valid,
    output logic signed [WIDTH-1:0] out_median
);

    logic signed [WIDTH-1:0] a_q;
    logic signed [WIDTH-1:0] b_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic last;
    logic signed [WIDTH-1:0] med;

    // Median of three by comparing the newest value with the held two.
    function automatic logic signed [WIDTH-1:0] med3(
        input logic signed [WIDTH-1:0] x,
        input logic signed [WIDTH-1:0] y,
        input logic signed [WIDTH-1:0] z
    );
        logic signed [WIDTH-1:0] lo;
        logic signed [WIDTH-1:0] hi;
        // Order the first two, then clamp the third; equal values are safe.
        lo = (x < y) ? x : y;
        hi = (x < y) ? y : x;
        med3 = (z <= lo) ? lo : ((z >= hi) ? hi : z);
    endfunction : med3

    // The third scan of a group completes it.
    assign last = in_valid && (cnt_q == 2'h2);
    assign cnt_d = last ? 2'h0 : cnt_q + 2'h1;
    assign med = med3(a_q, b_q, in_diff);

    // Hold the first two results of the group and count scans.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            a_q <= '0;
            b_q <= '0;
            cnt_q <= 2'h0;
            out_valid <= 1'b0;
            out_median <= '0;
        end else if (ce) begin
            out_valid <= last;
            if (in_valid) begin
                cnt_q <= cnt_d;
                if (cnt_q == 2'h0) begin
                    a_q <= in_diff;
                end
                if (cnt_q == 2'h1) begin
                    b_q <= in_diff;
                end
                if (last) begin
                    out_median <= med;
                end
            end
        end
    end

endmodule : tbs_median3

`default_nettype wire

/* File: hw/tbs_debounce.sv */
`timescale 1ns/1ps
`default_nettype none

// Sensor state decision with hysteresis and scan debounce.
module tbs_debounce #(
    parameter int WIDTH = 17
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic step,
    input wire logic signed [WIDTH-1:0] diff,
    input wire logic [15:0] finger,
    input wire logic [15:0] hyst,
    input wire logic [15:0] debounce,
    output logic touch
);

    logic [15:0] run_q;
    logic [15:0] run_d;
    logic signed [WIDTH+1:0] sig;
    logic signed [WIDTH+1:0] on_lvl;
    logic signed [WIDTH+1:0] off_lvl;
    logic above;
    logic below;

    // Signed comparisons against both hysteresis edges.
    assign sig = (WIDTH+2)'(diff);
    assign on_lvl = (WIDTH+2)'({1'b0, finger}) + (WIDTH+2)'({1'b0, hyst});
    assign off_lvl = (WIDTH+2)'({1'b0, finger}) - (WIDTH+2)'({1'b0, hyst});
    assign above = sig >= on_lvl;
    assign below = sig <= off_lvl;
    // Saturating run length so long touches never wrap back to zero.
    assign run_d = (run_q == 16'hFFFF) ? run_q : run_q + 16'h0001;

    // A qualifying run must reach the debounce count before ON.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_q <= 16'h0000;
            touch <= 1'b0;
        end else if (ce && step) begin
            if (above) begin
                run_q <= run_d;
                if (run_d >= debounce) begin
                    touch <= 1'b1;
                end
            end else begin
                run_q <= 16'h0000;
                if (below) begin
                    touch <= 1'b0;
                end
            end
            // Between the two levels the reported state is left alone.
        end
    end

    a_on_needs_above: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(touch) |-> $past(above))
        else $error("Touch rose without signal above on level.");

    a_off_when_below: assert property (@(posedge clock) disable iff (!rst_n)
        ce && step && below |=> !touch)
        else $error("Touch not cleared below off level.");

    a_hold_between: assert property (@(posedge clock) disable iff (!rst_n)
        ce && step && !above && !below |=> touch == $past(touch))
        else $error("Touch changed inside hysteresis band.");

endmodule : tbs_debounce

`default_nettype wire

/* File: hw/tbs_tracker.sv */
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tbs_defines.svh"

// Summary of operation
// - Signal equals raw count minus baseline
// - ON above threshold plus hysteresis, OFF below minus
// - Without auto reset, freeze baseline on high raw
// - Hold baseline while raw is abnormally low
// - Low count reaching limit reloads baseline
// - Only consecutive low scans count
// - First raw count seeds the baseline
// - ON only after debounce consecutive qualifying scans, or medians with multi-frequency
// - Without auto reset, filter only inside window
// - With auto reset, filter whenever not low
// - Multi-frequency uses median of three differences
// - No touch gives fixed centroid code
module tbs_tracker #(
    parameter int RAW_W = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic raw_valid,
    input wire logic [RAW_W-1:0] raw_count,
    output logic touch,
    output logic [15:0] centroid,
    output logic [RAW_W-1:0] baseline,
    output logic signed [RAW_W:0] diff_count,
    output logic diff_valid
);

    localparam int DW = RAW_W + 1;
    localparam int EW = RAW_W + 2;
    localparam logic [15:0] RST_CTRL = `TBS_RST_CTRL;

    tbs_pkg::tbs_bus_type bus;
    tbs_pkg::tbs_cfg_type cfg_q;
    tbs_pkg::tbs_phase_type phase_q;
    logic [15:0] ctrl_q;
    logic [RAW_W-1:0] base_q;
    logic [RAW_W-1:0] base_d;
    logic [15:0] low_q;
    logic [15:0] low_d;
    logic signed [EW-1:0] raw_e;
    logic signed [EW-1:0] base_e;
    logic signed [EW-1:0] diff_e;
    logic signed [DW-1:0] diff_now;
    logic is_high;
    logic is_low;
    logic do_filter;
    logic low_hit;
    logic [RAW_W-1:0] filtered;
    logic med_valid;
    logic signed [DW-1:0] med_diff;
    logic step;
    logic signed [DW-1:0] step_diff;
    logic signed [DW-1:0] diff_q;
    logic step_q;
    logic [15:0] rd_mux;

    // Bundle the register port so decoding reads one carrier.
    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Low pass step, truncated but never below one count, so it always arrives.
    function automatic logic [RAW_W-1:0] lp_step(
        input logic [RAW_W-1:0] b,
        input logic [RAW_W-1:0] r,
        input logic [3:0] k
    );
        logic [RAW_W-1:0] d;
        logic [RAW_W-1:0] s;
        d = (r >= b) ? r - b : b - r;
        s = d >> k;
        if (s == '0 && d != '0) begin
            s = {{(RAW_W-1){1'b0}}, 1'b1};
        end
        lp_step = (r >= b) ? b + s : b - s;
    endfunction : lp_step

    // Signed difference and window tests against the current baseline.
    assign raw_e = $signed({2'b00, raw_count});
    assign base_e = $signed({2'b00, base_q});
    assign diff_e = raw_e - base_e;
    assign diff_now = diff_e[DW-1:0];
    assign is_high = raw_e > base_e + $signed({2'b00, cfg_q.noise});
    assign is_low = raw_e < base_e - $signed({2'b00, cfg_q.neg_noise});
    assign do_filter = cfg_q.auto_reset ? !is_low : (!is_low && !is_high);
    assign low_d = (low_q == 16'hFFFF) ? low_q : low_q + 16'h0001;
    assign low_hit = is_low && (low_d >= cfg_q.low_reset);
    assign filtered = lp_step(base_q, raw_count, cfg_q.shift);

    // Next baseline: seed, low reset, filter, or hold.
    always_comb begin
        base_d = base_q;
        if (phase_q == tbs_pkg::TBS_FIRST) begin
            base_d = raw_count;
        end else if (low_hit) begin
            base_d = raw_count;
        end else if (do_filter) begin
            base_d = filtered;
        end
        // High raw without auto reset, and short low runs, keep base.
    end

    // Baseline and low-run counter advance once per raw count.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            base_q <= '0;
            low_q <= 16'h0000;
            phase_q <= tbs_pkg::TBS_FIRST;
        end else if (ce && raw_valid) begin
            base_q <= base_d;
            phase_q <= tbs_pkg::TBS_TRACK;
            if (phase_q == tbs_pkg::TBS_FIRST || !is_low || low_hit) begin
                low_q <= 16'h0000;
            end else begin
                low_q <= low_d;
            end
        end
    end

    // Optional median stage for multi-frequency scanning.
    tbs_median3 #(
        .WIDTH(DW)
    ) u_median (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(raw_valid && cfg_q.multi_freq),
        .in_diff(diff_now),
        .out_valid(med_valid),
        .out_median(med_diff)
    );

    // Pick the difference that drives the state decision.
    assign step = cfg_q.multi_freq ? med_valid : step_q;
    assign step_diff = cfg_q.multi_freq ? med_diff : diff_q;

    // Register the single-scan difference for matched timing.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            diff_q <= '0;
            step_q <= 1'b0;
        end else if (ce) begin
            step_q <= raw_valid && !cfg_q.multi_freq;
            if (raw_valid) begin
                diff_q <= diff_now;
            end
        end
    end

    tbs_debounce #(
        .WIDTH(DW)
    ) u_state (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .step(step),
        .diff(step_diff),
        .finger(cfg_q.finger),
        .hyst(cfg_q.hyst),
        .debounce(cfg_q.debounce),
        .touch(touch)
    );

    // Configuration writes; the control word unpacks into fields.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_q.finger <= `TBS_RST_FINGER;
            cfg_q.hyst <= `TBS_RST_HYST;
            cfg_q.noise <= `TBS_RST_NOISE;
            cfg_q.neg_noise <= `TBS_RST_NEG_NOISE;
            cfg_q.low_reset <= `TBS_RST_LOW_RESET;
            cfg_q.debounce <= `TBS_RST_DEBOUNCE;
            ctrl_q <= `TBS_RST_CTRL;
            cfg_q.auto_reset <= RST_CTRL[`TBS_CTRL_AUTO_RESET];
            cfg_q.multi_freq <= RST_CTRL[`TBS_CTRL_MULTI_FREQ];
            cfg_q.notouch_ones <= RST_CTRL[`TBS_CTRL_NOTOUCH_ONES];
            cfg_q.shift <= RST_CTRL[`TBS_CTRL_SHIFT_HI:`TBS_CTRL_SHIFT_LO];
        end else if (ce && bus.wr) begin
            case (bus.addr)
                `TBS_OFF_FINGER: cfg_q.finger <= bus.wdata;
                `TBS_OFF_HYST: cfg_q.hyst <= bus.wdata;
                `TBS_OFF_NOISE: cfg_q.noise <= bus.wdata;
                `TBS_OFF_NEG_NOISE: cfg_q.neg_noise <= bus.wdata;
                `TBS_OFF_LOW_RESET: cfg_q.low_reset <= bus.wdata;
                `TBS_OFF_DEBOUNCE: cfg_q.debounce <= bus.wdata;
                `TBS_OFF_CTRL: begin
                    // Fields load with the word, so the struct has one driver.
                    ctrl_q <= bus.wdata;
                    cfg_q.auto_reset <= bus.wdata[`TBS_CTRL_AUTO_RESET];
                    cfg_q.multi_freq <= bus.wdata[`TBS_CTRL_MULTI_FREQ];
                    cfg_q.notouch_ones <= bus.wdata[`TBS_CTRL_NOTOUCH_ONES];
                    cfg_q.shift <=
                        bus.wdata[`TBS_CTRL_SHIFT_HI:`TBS_CTRL_SHIFT_LO];
                end
                default: ;
            endcase
        end
    end

    // Read selection; unmapped offsets read as zero.
    always_comb begin
        case (bus.addr)
            `TBS_OFF_FINGER: rd_mux = cfg_q.finger;
            `TBS_OFF_HYST: rd_mux = cfg_q.hyst;
            `TBS_OFF_NOISE: rd_mux = cfg_q.noise;
            `TBS_OFF_NEG_NOISE: rd_mux = cfg_q.neg_noise;
            `TBS_OFF_LOW_RESET: rd_mux = cfg_q.low_reset;
            `TBS_OFF_DEBOUNCE: rd_mux = cfg_q.debounce;
            `TBS_OFF_CTRL: rd_mux = ctrl_q;
            `TBS_OFF_STATUS: rd_mux = {15'h0000, touch};
            `TBS_OFF_BASELINE: rd_mux = 16'(base_q);
            `TBS_OFF_SIGNAL: rd_mux = 16'(step_diff);
            `TBS_OFF_CENTROID: rd_mux = centroid;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data stands one cycle after the strobe, only then.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            reg_rdata <= bus.rd ? rd_mux : 16'h0000;
        end
    end

    // The centroid arithmetic lives elsewhere; here only no-touch code.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            centroid <= `TBS_CENTROID_ZEROS;
            diff_valid <= 1'b0;
            diff_count <= '0;
        end else if (ce) begin
            diff_valid <= step;
            if (step) begin
                diff_count <= step_diff;
            end
            if (!touch) begin
                centroid <= cfg_q.notouch_ones ? `TBS_CENTROID_ONES
                    : `TBS_CENTROID_ZEROS;
            end
        end
    end

    assign baseline = base_q;

    a_first_seeds: assert property (@(posedge clock) disable iff (!rst_n)
        ce && raw_valid && phase_q == tbs_pkg::TBS_FIRST
        |=> base_q == $past(raw_count))
        else $error("Baseline not seeded from first raw count.");

    a_high_freezes: assert property (@(posedge clock) disable iff (!rst_n)
        ce && raw_valid && phase_q == tbs_pkg::TBS_TRACK && is_high
        && !cfg_q.auto_reset |=> $stable(base_q))
        else $error("Baseline moved on high raw count.");

    a_low_holds: assert property (@(posedge clock) disable iff (!rst_n)
        ce && raw_valid && phase_q == tbs_pkg::TBS_TRACK && is_low
        && !low_hit |=> $stable(base_q))
        else $error("Baseline moved during short low run.");

    a_low_reset: assert property (@(posedge clock) disable iff (!rst_n)
        ce && raw_valid && phase_q == tbs_pkg::TBS_TRACK && low_hit
        |=> base_q == $past(raw_count) && low_q == 16'h0000)
        else $error("Low baseline reset did not reload.");

    a_low_clears: assert property (@(posedge clock) disable iff (!rst_n)
        ce && raw_valid && !is_low |=> low_q == 16'h0000)
        else $error("Low scan count not cleared.");

    a_filter_moves: assert property (@(posedge clock) disable iff (!rst_n)
        ce && raw_valid && phase_q == tbs_pkg::TBS_TRACK && do_filter
        && !low_hit |=> base_q == $past(filtered))
        else $error("Baseline filter step missing.");

    a_diff_value: assert property (@(posedge clock) disable iff (!rst_n)
        ce && raw_valid && !cfg_q.multi_freq
        |=> diff_q == $past(raw_e - base_e))
        else $error("Difference is not raw minus baseline.");

    a_notouch_code: assert property (@(posedge clock) disable iff (!rst_n)
        ce && !touch && cfg_q.notouch_ones |=> centroid == 16'hFFFF)
        else $error("No-touch centroid code wrong.");

endmodule : tbs_tracker

`default_nettype wire

/* File: bench/tbs_scan_source.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural converter model: one raw count per requested scan, after a
// chosen number of idle cycles, so prompt and slow scans can both be made.
module tbs_scan_source (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [15:0] value,
    input wire logic [3:0] gap,
    output logic raw_valid,
    output logic [15:0] raw_count
);
    logic pend_q;
    logic [3:0] wait_q;
    logic [15:0] held_q;

    // Between scans the count lines toggle every cycle, so a stale value
    // can never pass for a fresh one.
    always_ff @(posedge clock) begin
        raw_valid <= 1'b0;
        raw_count <= ~raw_count;
        if (!rst_n) begin
            pend_q <= 1'b0;
            raw_count <= 16'hA5A5;
        end else if (go) begin
            pend_q <= 1'b1;
            wait_q <= gap;
            held_q <= value;
        end else if (pend_q && wait_q == 4'h0) begin
            raw_valid <= 1'b1;
            raw_count <= held_q;
            pend_q <= 1'b0;
        end else if (pend_q) begin
            wait_q <= wait_q - 4'h1;
        end
    end
endmodule : tbs_scan_source

`default_nettype wire

/* File: bench/tbs_tracker_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbs_defines.svh"

module tbs_tracker_test;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic go = 1'b0;
    logic [15:0] go_value = 16'h0000;
    logic [3:0] go_gap = 4'h0;
    logic raw_valid;
    logic [15:0] raw_count;
    logic touch;
    logic [15:0] centroid;
    logic [15:0] baseline;
    logic signed [16:0] diff_count;
    logic diff_valid;
    int error_cnt = 0;
    int comparisons = 0;
    int pulses = 0;
    int total_pulses = 0;
    logic [15:0] b = 16'h0000;
    logic [15:0] rd_val;
    logic [16:0] last_diff = 17'h00000;
    logic [15:0] rst_tbl [7] = '{`TBS_RST_FINGER, `TBS_RST_HYST,
        `TBS_RST_NOISE, `TBS_RST_NEG_NOISE, `TBS_RST_LOW_RESET,
        `TBS_RST_DEBOUNCE, `TBS_RST_CTRL};
    logic [15:0] mf_tbl [3] = '{16'h0096, 16'h0064, 16'h00C8};

    // Free-running 50 MHz system clock.
    always #10 clock = ~clock;

    tbs_tracker i_dut (.clock(clock), .rst_n(rst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_valid(raw_valid),
        .raw_count(raw_count), .touch(touch), .centroid(centroid),
        .baseline(baseline), .diff_count(diff_count),
        .diff_valid(diff_valid));

    tbs_scan_source i_source (.clock(clock), .rst_n(rst_n), .go(go),
        .value(go_value), .gap(go_gap), .raw_valid(raw_valid),
        .raw_count(raw_count));

    // Reference low-pass step with the reset shift of two.
    function automatic logic [15:0] lp(input logic [15:0] bb,
                                       input logic [15:0] r);
        logic [15:0] step;
        step = (r > bb) ? (r - bb) >> 2 : (bb - r) >> 2;
        if (step == 16'h0000) step = 16'h0001;
        if (r == bb) return bb;
        return (r > bb) ? bb + step : bb - step;
    endfunction : lp

    task automatic check(input string what, input logic [16:0] exp,
                         input logic [16:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        b = 16'h0000;
    endtask : do_reset

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe.
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // Ask the converter for one scan, then watch a fixed window that covers
    // the documented latency plus the requested idle gap.
    task automatic scan(input logic [15:0] raw, input logic [3:0] gap);
        @(posedge clock);
        go <= 1'b1;
        go_value <= raw;
        go_gap <= gap;
        @(posedge clock);
        go <= 1'b0;
        pulses = 0;
        repeat (int'(gap) + 6) begin
            @(posedge clock);
            #1;
            if (diff_valid === 1'b1) begin
                pulses++;
                last_diff = diff_count;
            end
        end
        total_pulses += pulses;
    endtask : scan

    // Mode 0 holds the baseline, 1 filters it, 2 loads the raw count.
    task automatic run_scan(input logic [15:0] raw, input logic [3:0] gap,
                            input int mode, input logic exp_touch);
        logic [16:0] exp_diff;
        exp_diff = {1'b0, raw} - {1'b0, b};
        scan(raw, gap);
        if (mode == 1) b = lp(b, raw);
        if (mode == 2) b = raw;
        else check("difference", exp_diff, last_diff);
        check("baseline", {1'b0, b}, {1'b0, baseline});
        check("touch", {16'h0000, exp_touch}, {16'h0000, touch});
        check("diff pulses", 17'h00001, 17'(pulses));
    endtask : run_scan

    // Main sequence of tests.
    initial begin
        do_reset();
        for (int i = 0; i < 7; i++) begin
            reg_read(4'(i), rd_val);
            check("config reset", {1'b0, rst_tbl[i]}, {1'b0, rd_val});
        end
        reg_write(4'hB, 16'hFFFF);
        reg_read(4'hB, rd_val);
        check("unmapped read", 17'h00000, {1'b0, rd_val});
        check("centroid", 17'h00000, {1'b0, centroid});
        $display("test registers done");

        run_scan(16'h03E8, 4'h0, 2, 1'b0);
        run_scan(b + 16'h0014, 4'h3, 1, 1'b0);
        run_scan(b - 16'h0014, 4'h0, 1, 1'b0);
        $display("test baseline filter done");

        run_scan(b + 16'h0064, 4'h0, 0, 1'b0);
        run_scan(b + 16'h0050, 4'h0, 0, 1'b0);
        run_scan(b + 16'h0064, 4'h1, 0, 1'b0);
        run_scan(b + 16'h0064, 4'h0, 0, 1'b0);
        run_scan(b + 16'h0064, 4'h0, 0, 1'b1);
        reg_read(`TBS_OFF_STATUS, rd_val);
        check("status", 17'h00001, {1'b0, rd_val});
        run_scan(b + 16'h0050, 4'h2, 0, 1'b1);
        run_scan(b + 16'h0046, 4'h0, 0, 1'b0);
        reg_write(`TBS_OFF_DEBOUNCE, 16'h0001);
        run_scan(b + 16'h005A, 4'h0, 0, 1'b1);
        run_scan(b + 16'h0047, 4'h0, 0, 1'b1);
        run_scan(b + 16'h0046, 4'h0, 0, 1'b0);
        check("centroid", 17'h00000, {1'b0, centroid});
        reg_write(`TBS_OFF_CTRL, 16'h0024);
        run_scan(b, 4'h0, 1, 1'b0);
        check("centroid", 17'h0FFFF, {1'b0, centroid});
        reg_read(`TBS_OFF_CENTROID, rd_val);
        check("centroid reg", 17'h0FFFF, {1'b0, rd_val});
        $display("test sensor state done");

        reg_write(`TBS_OFF_LOW_RESET, 16'h0003);
        run_scan(b - 16'h0032, 4'h0, 0, 1'b0);
        run_scan(b - 16'h0032, 4'h0, 0, 1'b0);
        run_scan(b + 16'h000A, 4'h0, 1, 1'b0);
        run_scan(b - 16'h0032, 4'h0, 0, 1'b0);
        run_scan(b - 16'h0032, 4'h2, 0, 1'b0);
        run_scan(b - 16'h0032, 4'h0, 2, 1'b0);
        $display("test low baseline done");

        reg_write(`TBS_OFF_CTRL, 16'h0025);
        run_scan(b + 16'h0064, 4'h0, 1, 1'b1);
        run_scan(b - 16'h0032, 4'h0, 0, 1'b0);
        $display("test auto reset done");

        ce <= 1'b0;
        reg_write(`TBS_OFF_FINGER, 16'h0001);
        ce <= 1'b1;
        reg_read(`TBS_OFF_FINGER, rd_val);
        check("frozen write", 17'h00050, {1'b0, rd_val});
        $display("test clock enable done");

        // Multi-frequency groups count from reset, so restart the block.
        do_reset();
        reg_write(`TBS_OFF_CTRL, 16'h0022);
        total_pulses = 0;
        scan(16'h03E8, 4'h0);
        for (int i = 2; i <= 9; i++) begin
            scan(16'h03E8 + mf_tbl[i % 3], 4'(i % 3));
        end
        check("group pulses", 17'h00003, 17'(total_pulses));
        check("median", 17'h00096, last_diff);
        check("baseline", 17'h003E8, {1'b0, baseline});
        check("touch", 17'h00001, {16'h0000, touch});
        $display("test multi frequency done");
        finish_test();
    end
endmodule : tbs_tracker_test

`default_nettype wire
